// [rtl/mgp_port.sv]
`timescale 1ns/1ps
module mgp_port
  import mgp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        core_ce,
  input  wire logic        mii_select,
  input  wire logic        address_tap_enable,
  input  wire logic        frame_tagging_enable,
  input  wire logic        time_base_select,
  input  wire logic        time_base_clock_input,
  input  wire logic        mii_rx_clk,
  input  wire logic [3:0]  mii_rxd,
  input  wire logic        mii_rx_dv,
  input  wire logic        mii_rx_er,
  input  wire logic        mii_col,
  input  wire logic        mii_crs,
  input  wire logic        serial_rx_clock,
  input  wire logic        serial_rx_bit,
  input  wire logic        serial_rx_enable,
  input  wire logic        serial_collision_in,
  input  wire logic        mii_tx_clk,
  input  wire logic        serial_tx_clock,
  input  wire logic        external_address_reject_n,
  input  wire logic        internal_reject_in,
  input  wire logic        nibble_mode_tag_data_in,
  input  wire logic        nibble_mode_tag_enable_in,
  input  wire logic        tx_valid,
  input  wire logic [3:0]  tx_data,
  input  wire logic        tx_last,
  output logic             tx_ready,
  output logic [3:0]       mii_txd,
  output logic             mii_tx_en,
  output logic             mii_tx_er,
  output logic             serial_tx_bit,
  output logic             serial_tx_enable,
  output logic [3:0]       rx_nibble,
  output logic             rx_nibble_valid,
  output logic             rx_frame_done,
  output logic             rx_crc_error,
  output logic             rx_frame_reject,
  output logic             carrier_sense,
  output logic             collision,
  output logic             frame_byte_delimiter,
  output logic             serial_rx_data_tap,
  output logic             serial_rx_clock_tap,
  output logic             tag_data_in,
  output logic             tag_enable_in,
  input  wire logic        mgmt_start,
  input  wire logic        mgmt_read,
  input  wire logic [4:0]  mgmt_phy_addr,
  input  wire logic [4:0]  mgmt_reg_addr,
  input  wire logic [15:0] mgmt_wdata,
  output logic             mgmt_busy,
  output logic             mgmt_done,
  output logic [15:0]      mgmt_rdata,
  output logic             mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe
);

  logic [SY_W-1:0] pins_raw;
  logic [SY_W-1:0] pins_s;
  logic [SY_W-1:0] pins_p;
  logic            rx_edge;
  logic            rx_valid_in;
  logic            tx_edge;
  logic            nib_tick;
  logic [3:0]      rxd_s;
  mgp_rx_state_t   rx_state_q;
  logic            rx_prev_bit_q;
  logic            rx_first_q;
  logic [1:0]      rx_cnt_q;
  logic [1:0]      rx_idx;
  logic [3:0]      rx_shift_q;
  logic            rx_err_q;
  logic            rx_rej_q;
  mgp_tx_state_t   tx_state_q;
  mgp_tx_state_t   tx_state_d;
  logic [3:0]      tx_cnt_q;
  logic [3:0]      tx_cnt_d;
  logic [3:0]      nib_d;
  logic            en_d;
  logic [1:0]      tx_phase_q;
  logic [1:0]      tx_phase_nx;
  logic [3:0]      stx_nib_q;
  mgp_mg_state_t   mg_state_q;
  logic [63:0]     mg_frame_q;
  logic [5:0]      mg_bit_q;
  logic [5:0]      mg_bit_nx;
  logic [1:0]      mg_half_q;
  logic            mg_read_q;
  logic            mg_tick;

  // Every pin from outside the core clock passes two flops
  assign pins_raw = {nibble_mode_tag_enable_in, nibble_mode_tag_data_in, mdio_i,
                     time_base_clock_input, external_address_reject_n, serial_tx_clock,
                     mii_tx_clk, serial_collision_in, serial_rx_enable, serial_rx_bit,
                     serial_rx_clock, mii_col, mii_crs, mii_rx_er, mii_rx_dv, mii_rxd,
                     mii_rx_clk};

  mgp_sync #(.W(SY_W)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .core_ce  (core_ce),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  // Previous synchronised levels for edge detection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pins_p <= '0;
    end else if (core_ce) begin
      pins_p <= pins_s;
    end
  end

  // Receive edge and valid select by port mode
  assign rxd_s       = pins_s[SY_RXD +: 4];
  assign rx_edge     = core_ce & (mii_select ? (pins_s[SY_SERIAL_RX_CLOCK] & ~pins_p[SY_SERIAL_RX_CLOCK])
                                             : (pins_s[SY_SRXCLK] & ~pins_p[SY_SRXCLK]));
  assign rx_valid_in = mii_select ? pins_s[SY_DV] : pins_s[SY_SRXEN];
  assign tx_edge     = core_ce & (mii_select ? (pins_s[SY_SERIAL_TX_CLOCK] & ~pins_p[SY_SERIAL_TX_CLOCK])
                                             : (pins_s[SY_STXCLK] & ~pins_p[SY_STXCLK]));
  assign mii_tx_er   = 1'b0;

  // Receive framing: preamble hunt and start delimiter detection
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_state_q    <= RX_IDLE;
      rx_prev_bit_q <= 1'b0;
    end else if (rx_edge) begin
      if (!rx_valid_in) begin
        rx_state_q    <= RX_IDLE;
        rx_prev_bit_q <= 1'b0;
      end else begin
        rx_prev_bit_q <= pins_s[SY_SRXBIT];
        case (rx_state_q)
          RX_IDLE, RX_PRE: begin
            if (mii_select) begin
              if (rxd_s == NIB_SFD && !pins_s[SY_ER]) begin
                rx_state_q <= RX_FRAME;
              end else begin
                rx_state_q <= RX_PRE;
              end
            end else if (rx_state_q == RX_PRE && rx_prev_bit_q && pins_s[SY_SRXBIT]) begin
              rx_state_q <= RX_FRAME;
            end else begin
              rx_state_q <= RX_PRE;
            end
          end
          RX_FRAME: rx_state_q <= RX_FRAME;
          default:  rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // Position within the nibble being received
  assign rx_idx = rx_first_q ? BIT_FIRST : (rx_cnt_q + BIT_STEP);

  // Frame-byte delimiter and received nibbles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      frame_byte_delimiter <= 1'b0;
      rx_first_q           <= 1'b1;
      rx_cnt_q             <= BIT_FIRST;
      rx_shift_q           <= NIB_ZERO;
      rx_nibble            <= NIB_ZERO;
      rx_nibble_valid      <= 1'b0;
    end else if (core_ce) begin
      rx_nibble_valid <= 1'b0;
      if (rx_edge && rx_valid_in && rx_state_q == RX_FRAME) begin
        rx_first_q <= 1'b0;
        rx_cnt_q   <= rx_idx;
        if (rx_first_q) begin
          frame_byte_delimiter <= 1'b1;
        end else if (mii_select || rx_idx == BIT_FIRST) begin
          frame_byte_delimiter <= ~frame_byte_delimiter;
        end
        if (mii_select) begin
          rx_nibble       <= rxd_s;
          rx_nibble_valid <= 1'b1;
        end else begin
          rx_shift_q <= {pins_s[SY_SRXBIT], rx_shift_q[3:1]};
          if (rx_idx == BIT_LAST) begin
            rx_nibble       <= {pins_s[SY_SRXBIT], rx_shift_q[3:1]};
            rx_nibble_valid <= 1'b1;
          end
        end
      end else if (rx_state_q != RX_FRAME || (rx_edge && !rx_valid_in)) begin
        frame_byte_delimiter <= 1'b0;
        rx_first_q           <= 1'b1;
        rx_cnt_q             <= BIT_FIRST;
      end
    end
  end

  // Frame status: coding error and reject gathered over the frame
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_err_q        <= 1'b0;
      rx_rej_q        <= 1'b0;
      rx_frame_done   <= 1'b0;
      rx_crc_error    <= 1'b0;
      rx_frame_reject <= 1'b0;
    end else if (core_ce) begin
      rx_frame_done <= 1'b0;
      if (rx_state_q == RX_FRAME && rx_edge && !rx_valid_in) begin
        rx_frame_done   <= 1'b1;
        rx_crc_error    <= rx_err_q;
        rx_frame_reject <= rx_rej_q | ~pins_s[SY_EAR_N] | internal_reject_in;
        rx_err_q        <= 1'b0;
        rx_rej_q        <= 1'b0;
      end else if (rx_state_q == RX_FRAME) begin
        if (rx_edge && mii_select && pins_s[SY_DV] && pins_s[SY_ER]) begin
          rx_err_q <= 1'b1;
        end
        if (!pins_s[SY_EAR_N]) begin
          rx_rej_q <= 1'b1;
        end
      end else begin
        rx_err_q <= 1'b0;
        rx_rej_q <= 1'b0;
      end
    end
  end

  // Medium status, serial taps and tag input routing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      carrier_sense       <= 1'b0;
      collision           <= 1'b0;
      serial_rx_data_tap  <= 1'b0;
      serial_rx_clock_tap <= 1'b0;
      tag_data_in         <= 1'b0;
      tag_enable_in       <= 1'b0;
    end else if (core_ce) begin
      carrier_sense <= mii_select ? pins_s[SY_CRS] : pins_s[SY_SRXEN];
      collision     <= mii_select ? pins_s[SY_COL] : pins_s[SY_SCOL];
      if (mii_select) begin
        serial_rx_data_tap  <= 1'b0;
        serial_rx_clock_tap <= 1'b0;
      end else begin
        serial_rx_clock_tap <= pins_s[SY_SRXCLK];
        if (rx_edge && pins_s[SY_SRXEN]) begin
          serial_rx_data_tap <= pins_s[SY_SRXBIT];
        end
      end
      if (address_tap_enable && frame_tagging_enable) begin
        tag_data_in   <= mii_select ? pins_s[SY_NTD] : rxd_s[0];
        tag_enable_in <= mii_select ? pins_s[SY_NTE] : pins_s[SY_DV];
      end else begin
        tag_data_in   <= 1'b0;
        tag_enable_in <= 1'b0;
      end
    end
  end

  // One nibble step per transmit clock, or per four serial bits
  assign nib_tick = tx_edge & (mii_select | (tx_phase_q == BIT_LAST));
  assign tx_ready = nib_tick & (tx_state_q == TX_DATA);

  // Transmit sequencer: preamble, delimiter, then user nibbles
  always_comb begin
    tx_state_d = tx_state_q;
    tx_cnt_d   = tx_cnt_q;
    nib_d      = NIB_ZERO;
    en_d       = 1'b0;
    case (tx_state_q)
      TX_IDLE: begin
        if (tx_valid) begin
          tx_state_d = TX_PRE;
          tx_cnt_d   = NIB_ZERO;
          nib_d      = NIB_PREAMBLE;
          en_d       = 1'b1;
        end
      end
      TX_PRE: begin
        en_d     = 1'b1;
        tx_cnt_d = tx_cnt_q + 4'h1;
        if (tx_cnt_q == TX_SFD_COUNT) begin
          nib_d      = NIB_SFD;
          tx_state_d = TX_DATA;
        end else begin
          nib_d = NIB_PREAMBLE;
        end
      end
      TX_DATA: begin
        if (tx_valid) begin
          nib_d      = tx_data;
          en_d       = 1'b1;
          tx_state_d = tx_last ? TX_LAST : TX_DATA;
        end else begin
          tx_state_d = TX_IDLE;
        end
      end
      TX_LAST:  tx_state_d = TX_IDLE;
      default:  tx_state_d = TX_IDLE;
    endcase
  end

  // Transmit sequencer state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q   <= NIB_ZERO;
    end else if (nib_tick) begin
      tx_state_q <= tx_state_d;
      tx_cnt_q   <= tx_cnt_d;
    end
  end

  // Nibble transmit pins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mii_txd   <= NIB_ZERO;
      mii_tx_en <= 1'b0;
    end else if (core_ce) begin
      if (!mii_select) begin
        mii_txd   <= NIB_ZERO;
        mii_tx_en <= 1'b0;
      end else if (nib_tick) begin
        mii_tx_en <= en_d;
        mii_txd   <= en_d ? nib_d : NIB_ZERO;
      end
    end
  end

  assign tx_phase_nx = tx_phase_q + BIT_STEP;

  // Serial transmit pins, low bit of each nibble first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_phase_q       <= BIT_LAST;
      stx_nib_q        <= NIB_ZERO;
      serial_tx_bit    <= 1'b0;
      serial_tx_enable <= 1'b0;
    end else if (core_ce) begin
      if (mii_select) begin
        tx_phase_q       <= BIT_LAST;
        serial_tx_bit    <= 1'b0;
        serial_tx_enable <= 1'b0;
      end else if (tx_edge) begin
        if (tx_phase_q == BIT_LAST) begin
          stx_nib_q        <= nib_d;
          serial_tx_bit    <= en_d & nib_d[0];
          serial_tx_enable <= en_d;
          tx_phase_q       <= en_d ? BIT_FIRST : BIT_LAST;
        end else begin
          serial_tx_bit <= stx_nib_q[tx_phase_nx];
          tx_phase_q    <= tx_phase_nx;
        end
      end
    end
  end

  // Management time base: every core cycle or external clock edges
  assign mg_tick = core_ce & (time_base_select ? (pins_s[SY_TBC] & ~pins_p[SY_TBC])
                                               : 1'b1);
  assign mg_bit_nx = mg_bit_q + MG_BIT_STEP;
  assign mgmt_busy = (mg_state_q == MG_RUN);

  // Management frame engine
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mg_state_q <= MG_IDLE;
      mg_frame_q <= '0;
      mg_bit_q   <= '0;
      mg_half_q  <= '0;
      mg_read_q  <= 1'b0;
      mdc        <= 1'b0;
      mdio_o     <= 1'b0;
      mdio_oe    <= 1'b0;
      mgmt_done  <= 1'b0;
      mgmt_rdata <= '0;
    end else if (core_ce) begin
      mgmt_done <= 1'b0;
      case (mg_state_q)
        MG_IDLE: begin
          mdc     <= 1'b0;
          mdio_oe <= 1'b0;
          if (mgmt_start) begin
            mg_state_q <= MG_RUN;
            mg_read_q  <= mgmt_read;
            mg_frame_q <= {MG_PREAMBLE, MG_START, mgmt_read ? MG_OP_READ : MG_OP_WRITE,
                           mgmt_phy_addr, mgmt_reg_addr,
                           mgmt_read ? MG_TA_READ : MG_TA_WRITE, mgmt_wdata};
            mg_bit_q   <= '0;
            mg_half_q  <= '0;
            mdio_o     <= MG_PREAMBLE[31];
            mdio_oe    <= 1'b1;
          end
        end
        MG_RUN: begin
          if (mg_tick) begin
            mg_half_q <= mg_half_q + 2'h1;
            if (mg_half_q == MDC_HALF_LAST) begin
              mg_half_q <= '0;
              if (!mdc) begin
                mdc <= 1'b1;
              end else begin
                mdc <= 1'b0;
                // Read bit taken at the end of its bit time, past the synchroniser delay
                if (mg_read_q && mg_bit_q >= MG_DATA_FIRST) begin
                  mgmt_rdata <= {mgmt_rdata[14:0], pins_s[SY_MDIO]};
                end
                if (mg_bit_q == MG_BIT_LAST) begin
                  mg_state_q <= MG_IDLE;
                  mdio_oe    <= 1'b0;
                  mgmt_done  <= 1'b1;
                end else begin
                  mg_bit_q   <= mg_bit_nx;
                  mg_frame_q <= {mg_frame_q[62:0], 1'b0};
                  mdio_o     <= mg_frame_q[62];
                  mdio_oe    <= !(mg_read_q && mg_bit_nx >= MG_TA_FIRST);
                end
              end
            end
          end
        end
        default: mg_state_q <= MG_IDLE;
      endcase
    end
  end

endmodule : mgp_port

// [rtl/mgp_pkg.sv]
package mgp_pkg;

  // Core clock and management clock rates
  localparam int CORE_CLK_KHZ   = 10000;
  localparam int MDC_NOM_KHZ    = 2500;
  localparam int MDC_HALF_TICKS = CORE_CLK_KHZ / (2 * MDC_NOM_KHZ);
  localparam logic [1:0] MDC_HALF_LAST = 2'(MDC_HALF_TICKS - 1);

  // Nibble values on the wire
  localparam logic [3:0] NIB_ZERO     = 4'h0;
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_SFD      = 4'hd;
  localparam logic [3:0] TX_SFD_COUNT = 4'he;  // Preamble step that emits the delimiter

  // Bit position within a nibble on the serial port
  localparam logic [1:0] BIT_FIRST = 2'h0;
  localparam logic [1:0] BIT_LAST  = 2'h3;
  localparam logic [1:0] BIT_STEP  = 2'h1;

  // Management frame layout
  localparam logic [31:0] MG_PREAMBLE   = 32'hffffffff;
  localparam logic [1:0]  MG_START      = 2'h1;
  localparam logic [1:0]  MG_OP_READ    = 2'h2;
  localparam logic [1:0]  MG_OP_WRITE   = 2'h1;
  localparam logic [1:0]  MG_TA_WRITE   = 2'h2;
  localparam logic [1:0]  MG_TA_READ    = 2'h0;
  localparam logic [5:0]  MG_BIT_LAST   = 6'h3f;
  localparam logic [5:0]  MG_TA_FIRST   = 6'h2e;
  localparam logic [5:0]  MG_DATA_FIRST = 6'h30;
  localparam logic [5:0]  MG_BIT_STEP   = 6'h01;

  // Bit positions in the synchronised pin vector
  localparam int SY_W      = 20;
  localparam int SY_SERIAL_RX_CLOCK  = 0;
  localparam int SY_RXD    = 1;
  localparam int SY_DV     = 5;
  localparam int SY_ER     = 6;
  localparam int SY_CRS    = 7;
  localparam int SY_COL    = 8;
  localparam int SY_SRXCLK = 9;
  localparam int SY_SRXBIT = 10;
  localparam int SY_SRXEN  = 11;
  localparam int SY_SCOL   = 12;
  localparam int SY_SERIAL_TX_CLOCK  = 13;
  localparam int SY_STXCLK = 14;
  localparam int SY_EAR_N  = 15;
  localparam int SY_TBC    = 16;
  localparam int SY_MDIO   = 17;
  localparam int SY_NTD    = 18;
  localparam int SY_NTE    = 19;

  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_LAST} mgp_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_FRAME} mgp_rx_state_t;
  typedef enum logic {MG_IDLE, MG_RUN} mgp_mg_state_t;

endpackage : mgp_pkg

// [rtl/mgp_sync.sv]
`timescale 1ns/1ps
module mgp_sync
  import mgp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         core_ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // Two flip-flop chain; the first stage feeds only the second
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (core_ce) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : mgp_sync

// [sim/mgp_port_assertions.sv]
`timescale 1ns/1ps
module mgp_port_chk (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       mii_select,
  input wire logic       address_tap_enable,
  input wire logic       frame_tagging_enable,
  input wire logic       time_base_select,
  input wire logic       mgmt_start,
  input wire logic       mgmt_busy,
  input wire logic [3:0] mii_txd,
  input wire logic       mii_tx_en,
  input wire logic       mii_tx_er,
  input wire logic       rx_nibble_valid,
  input wire logic       frame_byte_delimiter,
  input wire logic       serial_rx_data_tap,
  input wire logic       serial_rx_clock_tap,
  input wire logic       tag_data_in,
  input wire logic       tag_enable_in,
  input wire logic       mdc,
  input wire logic       mdio_o,
  input wire logic       mdio_oe,
  input wire logic       serial_tx_bit,
  input wire logic       serial_tx_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Management start and clock high phase
  sequence s_mg_take; !mgmt_busy && mgmt_start; endsequence
  sequence s_mdc_half; mdc ##1 mdc ##1 !mdc; endsequence
  property p_txer; mii_tx_er == 1'b0; endproperty
  property p_txd_zero; !mii_tx_en |-> mii_txd == 4'h0; endproperty
  property p_mg_start; s_mg_take |=> mdio_oe && mdio_o; endproperty
  property p_mg_idle; !mgmt_busy && !$past(mgmt_busy) |-> !mdc && !mdio_oe; endproperty
  property p_mdc_rate; !time_base_select && $rose(mdc) |-> s_mdc_half; endproperty
  property p_mdio_fall; mdio_oe && $changed(mdio_o) |-> !mdc; endproperty
  property p_delim; mii_select && $rose(frame_byte_delimiter) |-> rx_nibble_valid; endproperty
  property p_taps; mii_select && $past(mii_select) |-> !serial_rx_data_tap && !serial_rx_clock_tap;
  endproperty
  property p_tag_off;
    !(address_tap_enable && frame_tagging_enable) |=> !tag_data_in && !tag_enable_in;
  endproperty
  property p_stx_idle; !serial_tx_enable |-> !serial_tx_bit; endproperty
  a_stx_idle: assert property (p_stx_idle) else $error("serial bit set without enable");
  a_txer: assert property (p_txer) else $error("tx error output high");
  a_txd_zero: assert property (p_txd_zero) else $error("tx data nonzero while idle");
  a_mg_start: assert property (p_mg_start) else $error("mdio not driven at start");
  a_mg_idle: assert property (p_mg_idle) else $error("mdc or mdio active while idle");
  a_mdc_rate: assert property (p_mdc_rate) else $error("mdc high phase wrong");
  a_mdio_fall: assert property (p_mdio_fall) else $error("mdio changed with mdc high");
  a_delim: assert property (p_delim) else $error("delimiter rise off a nibble");
  a_taps: assert property (p_taps) else $error("serial taps move in nibble mode");
  a_tag_off: assert property (p_tag_off) else $error("tag outputs active while off");
endmodule : mgp_port_chk
bind mgp_port mgp_port_chk u_chk (.*);

// [sim/mgp_phy_model.sv]
`timescale 1ns/1ps
module mgp_phy_model (
  input  wire logic mdc,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      mdio_i,
  output logic      mii_rx_clk,
  output logic      mii_tx_clk,
  output logic [3:0] mii_rxd,
  output logic      mii_rx_dv,
  output logic      mii_rx_er,
  output logic      mii_crs,
  output logic      mii_col
);
  logic [15:0] rd_val = 16'ha5c3;
  int          cnt = 0;
  // Nibble clocks, clean pulses only, slow enough for the core to follow
  initial begin
    {mii_rx_clk, mii_tx_clk, mii_rxd, mii_rx_dv, mii_rx_er} = '0;
    forever begin
      #400;
      mii_rx_clk = ~mii_rx_clk;
      mii_tx_clk = ~mii_tx_clk;
    end
  end
  // Lines churn between frames so stale values never look valid
  always @(posedge mii_rx_clk) begin
    #20;
    if (!mii_rx_dv) begin
      mii_rxd = mii_rxd + 4'h3;
      mii_rx_er = ~mii_rx_er;
    end
  end
  assign mii_crs = mii_rx_dv;
  assign mii_col = 1'b0;
  // Read data follows the device releasing the line; pull-up otherwise
  always @(negedge mdc) begin
    #1;
    cnt = mdio_oe ? 0 : cnt + 1;
  end
  always @(posedge mdc) if (cnt >= 18) begin
    #150;
    cnt = 19;
  end
  assign mdio_i = mdio_oe ? mdio_o : (cnt < 2 || cnt > 18) ? 1'b1 :
                  (cnt == 2) ? 1'b0 : rd_val[18 - cnt];
  task automatic send(input logic [3:0] nib[$], input int er_at);
    foreach (nib[i]) begin
      @(posedge mii_rx_clk);
      #10;
      mii_rx_dv = 1'b1;
      mii_rxd = nib[i];
      mii_rx_er = (i == er_at);
    end
    @(posedge mii_rx_clk);
    #10;
    mii_rx_dv = 1'b0;
  endtask : send
endmodule : mgp_phy_model

// [sim/mgp_port_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module mgp_port_tb_top;
  logic core_clk, resetn, core_ce, mii_select, address_tap_enable, frame_tagging_enable;
  logic time_base_select, time_base_clock_input, external_address_reject_n, internal_reject_in;
  logic nibble_mode_tag_data_in, nibble_mode_tag_enable_in, tx_valid, tx_last, mgmt_start;
  logic mgmt_read, tx_ready, mii_tx_en, mii_tx_er, serial_tx_bit, serial_tx_enable;
  logic rx_nibble_valid, rx_frame_done, rx_crc_error, rx_frame_reject, carrier_sense, collision;
  logic frame_byte_delimiter, serial_rx_data_tap, serial_rx_clock_tap, tag_data_in;
  logic tag_enable_in, mgmt_busy, mgmt_done, mdc, mdio_o, mdio_oe, mdio_i;
  logic mii_rx_clk, mii_tx_clk, mii_rx_dv, mii_rx_er, mii_crs, mii_col;
  logic [3:0]  tx_data, mii_txd, rx_nibble, mii_rxd;
  logic [4:0]  mgmt_phy_addr, mgmt_reg_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [63:0] mg_sh;
  logic [3:0]  rxq[$], txq[$];
  logic        dlq[$];
  int          err_total = 0, n_compared = 0;
  // Serial pins share the nibble-port wires
  wire serial_rx_clock = mii_rx_clk, serial_rx_bit = mii_rx_er, serial_rx_enable = mii_crs;
  wire serial_collision_in = mii_col, serial_tx_clock = mii_tx_clk;
  mgp_port u_dut (.*);
  mgp_phy_model u_phy (.*);
  // Collect received nibbles, sent nibbles and management line bits
  always @(posedge core_clk) if (rx_nibble_valid) begin
    rxq.push_back(rx_nibble);
    dlq.push_back(frame_byte_delimiter);
  end
  always @(posedge mii_tx_clk) if (mii_tx_en) txq.push_back(mii_txd);
  always @(posedge mdc) mg_sh <= {mg_sh[62:0], mdio_i};
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic t_rx(input int er_at, input logic rej_n, input logic irj);
    logic [3:0] f[$];
    int         k;
    f = '{4'h5, 4'h5, 4'h5, 4'hd};
    for (k = 0; k < 8; k++) f.push_back(4'(k + 3));
    rxq.delete();
    dlq.delete();
    @(negedge core_clk);
    external_address_reject_n = rej_n;
    internal_reject_in = irj;
    u_phy.send(f, er_at);
    for (k = 0; k < 50 && rx_frame_done !== 1'b1; k++) @(negedge core_clk);
    `CHK(rxq.size(), 8, "rx count")
    for (k = 0; k < 8; k++) `CHK(rxq[k], 4'(k + 3), "rx nibble")
    for (k = 0; k < 8; k++) `CHK(dlq[k], ~k[0], "delimiter phase")
    `CHK(rx_crc_error, er_at >= 0, "crc flag")
    `CHK(rx_frame_reject, !rej_n || irj, "reject")
    `CHK(frame_byte_delimiter, 1'b0, "delimiter idle")
    $display("t_rx done");
  endtask : t_rx
  task automatic t_tx;
    int k = 0;
    int j;
    txq.delete();
    @(negedge core_clk);
    tx_data = 4'h1;
    tx_valid = 1'b1;
    for (j = 0; j < 600 && k < 6; j++) begin
      @(negedge core_clk);
      if (tx_ready) begin
        @(negedge core_clk);
        k++;
        tx_data = 4'(k + 1);
        tx_last = (k == 5);
      end
    end
    {tx_valid, tx_last} = 2'h0;
    repeat (40) @(negedge core_clk);
    `CHK(txq.size(), 22, "tx length")
    for (k = 0; k < 22; k++)
      `CHK(txq[k], k < 15 ? 4'h5 : k == 15 ? 4'hd : 4'(k - 15), "tx nibble")
    `CHK({mii_tx_en, mii_txd}, 5'h00, "tx idle")
    $display("t_tx done");
  endtask : t_tx
  task automatic t_mg(input logic rd);
    int k;
    @(negedge core_clk);
    {mgmt_read, mgmt_phy_addr, mgmt_reg_addr, mgmt_wdata} = {rd, 5'h01, 5'h1e, 16'h3c5a};
    mgmt_start = 1'b1;
    @(negedge core_clk);
    mgmt_start = 1'b0;
    `CHK(mdio_oe, 1'b1, "mdio driven")
    for (k = 0; k < 400 && mgmt_done !== 1'b1; k++) @(negedge core_clk);
    `CHK(mg_sh, {32'hffffffff, 2'h1, rd ? 2'h2 : 2'h1, 5'h01, 5'h1e, 2'h2,
                 rd ? u_phy.rd_val : 16'h3c5a}, "mgmt frame")
    if (rd) `CHK(mgmt_rdata, u_phy.rd_val, "read data")
    repeat (2) @(negedge core_clk);
    `CHK({mdc, mdio_oe}, 2'h0, "mgmt idle")
    $display("t_mg done");
  endtask : t_mg
  task automatic t_tag;
    @(negedge core_clk);
    {address_tap_enable, frame_tagging_enable} = 2'h3;
    {nibble_mode_tag_data_in, nibble_mode_tag_enable_in} = 2'h3;
    repeat (5) @(negedge core_clk);
    `CHK({tag_data_in, tag_enable_in}, 2'h3, "tag routed")
    nibble_mode_tag_data_in = 1'b0;
    repeat (5) @(negedge core_clk);
    `CHK({tag_data_in, tag_enable_in}, 2'h1, "tag data")
    frame_tagging_enable = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK({tag_data_in, tag_enable_in, serial_rx_data_tap}, 3'h0, "tag off")
    $display("t_tag done");
  endtask : t_tag
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #1000000;
    err_total++;
    final_report();
  end
  initial begin
    {resetn, tx_valid, tx_last, mgmt_start, mgmt_read, internal_reject_in} = '0;
    {address_tap_enable, frame_tagging_enable, time_base_select, time_base_clock_input} = '0;
    {nibble_mode_tag_data_in, nibble_mode_tag_enable_in, tx_data} = '0;
    {mgmt_phy_addr, mgmt_reg_addr, mgmt_wdata} = '0;
    {core_ce, mii_select, external_address_reject_n} = 3'h7;
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK({mii_tx_er, mdc, mdio_oe, frame_byte_delimiter}, 4'h0, "idle outputs")
    t_rx(-1, 1'b1, 1'b0);
    t_rx(6, 1'b0, 1'b0);
    t_rx(-1, 1'b1, 1'b1);
    t_tx();
    t_mg(1'b0);
    t_mg(1'b1);
    t_tag();
    final_report();
  end
endmodule : mgp_port_tb_top
